// file: hdl/iadc_pkg.sv
/*
  constants, field layout and state codes of the converter register block.
  assumes a 40 MHz bus clock and a four-byte window decoded outside.
*/
package iadc_pkg;

  localparam int DATA_W    = 8;
  localparam int IO_ADDR_W = 2;
  localparam int DOUT_W    = 4;
  localparam int CHAN_W    = 3;
  localparam int IRQ_LINES = 6;

  // byte locations inside the window
  localparam logic [1:0] LOC_START_ZERO   = 2'h0;
  localparam logic [1:0] LOC_RESULT       = 2'h1;
  localparam logic [1:0] LOC_STATUS       = 2'h2;
  localparam logic [1:0] LOC_STATUS_ALIAS = 2'h3;

  // status and control field positions
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_DIN_HI   = 6;
  localparam int STAT_DIN_LO   = 4;
  localparam int STAT_IRQ_BIT  = 3;
  localparam int CTRL_DOUT_HI  = 7;
  localparam int CTRL_DOUT_LO  = 4;
  localparam int CTRL_INTERRUPT_ENABLE_BIT_BIT = 3;
  localparam int CHAN_HI       = 2;
  localparam int CHAN_LO       = 0;

  // reset values
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [3:0] DOUT_RESET   = 4'h0;
  localparam logic [2:0] CHAN_RESET   = 3'h0;

  // interrupt level jumper: codes 2..7 route, others inactive
  localparam logic [2:0] IRQ_LEVEL_LO = 3'h2;

  // conversion time
  localparam int CLK_FREQ_HZ  = 40_000_000;
  localparam int CONV_TIME_NS = 20_000;
  localparam int CONV_CYCLES  =
    (CONV_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int CONV_CNT_W   = 10;
  localparam logic [9:0] CONV_LOAD = 10'(CONV_CYCLES - 1);
  localparam logic [9:0] CONV_ZERO = 10'h000;

  typedef enum logic [2:0] {
    CST_IDLE = 3'b001,
    CST_CONV = 3'b010,
    CST_HELD = 3'b100
  } iadc_conv_state_type;

endpackage

// file: hdl/iadc_conv_if.sv
/*
  start and done handshake between register block and conversion timer.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps

interface iadc_conv_if;
  logic start;
  logic done;
  modport ctrl  (output start, input done);
  modport timer (input start, output done);
endinterface

// file: hdl/iadc_conv_timer.sv
/*
  conversion timer: counts the conversion time after each start pulse.
  assumes start comes only while the timer is idle.
*/
`timescale 1ns/1ps

module iadc_conv_timer
  import iadc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // handshake with register block
  iadc_conv_if.timer conv
);

  typedef struct packed {
    logic                  active;
    logic [CONV_CNT_W-1:0] count;
    logic                  done;
  } iadc_timer_state_type;

  iadc_timer_state_type st_r;
  iadc_timer_state_type st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (conv.start) begin
      st_nxt.active = 1'b1;
      st_nxt.count  = CONV_LOAD;
    end else if (st_r.active) begin
      if (st_r.count == CONV_ZERO) begin
        st_nxt.active = 1'b0;
        st_nxt.done   = 1'b1;
      end else begin
        st_nxt.count = st_r.count - 10'h001;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign conv.done = st_r.done;

endmodule

// file: hdl/iadc_top.sv
/*
  host register block of an 8-bit acquisition card: conversion start,
  result read-back, status, control register and interrupt routing.
  assumes the base address is decoded outside into io_sel, that read
  and write strobes last one clock, and that all inputs are synchronous.
*/
`timescale 1ns/1ps

module iadc_top
  import iadc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // host i/o bus
  input  wire logic                 io_sel,
  input  wire logic [IO_ADDR_W-1:0] io_addr,
  input  wire logic                 io_wr,
  input  wire logic                 io_rd,
  input  wire logic [DATA_W-1:0]    io_wdata,
  output logic      [DATA_W-1:0]    io_rdata,
  output logic                      io_rvalid,
  // converter
  input  wire logic [DATA_W-1:0]    adc_sample,
  output logic                      conv_trigger,
  output logic                      conv_busy,
  // multiplexer channel
  output logic                      channel_select_bit2,
  output logic                      channel_select_bit1,
  output logic                      channel_select_bit0,
  // digital lines
  input  wire logic                 digital_input_3,
  input  wire logic                 digital_input_2,
  input  wire logic                 digital_input_1,
  output logic      [DOUT_W-1:0]    digital_output,
  // interrupt
  input  wire logic                 ext_int_in,
  input  wire logic [2:0]           irq_level_sel,
  output logic      [IRQ_LINES-1:0] irq_line
);

  typedef struct packed {
    iadc_conv_state_type  conv_state;
    logic [DATA_W-1:0]    result;
    logic [DOUT_W-1:0]    dout;
    logic                 int_enable;
    logic [CHAN_W-1:0]    channel;
    logic                 irq_pending;
    logic                 ext_int_prev;
    logic                 trigger;
    logic [DATA_W-1:0]    rdata;
    logic                 rvalid;
    logic [IRQ_LINES-1:0] irq_line;
  } iadc_top_state_type;

  iadc_top_state_type st_r;
  iadc_top_state_type st_nxt;

  iadc_conv_if conv ();

  // bus decode
  logic wr_any;
  logic rd_any;
  logic wr_start;
  logic wr_ctrl;
  logic rd_result;
  logic start_ok;
  logic int_edge;
  logic busy_now;
  logic [DATA_W-1:0] status_byte;

  assign wr_any = io_sel & io_wr;
  assign rd_any = io_sel & io_rd;

  // start on location 0 or 1
  assign wr_start = wr_any &
                    ((io_addr == LOC_START_ZERO) |
                     (io_addr == LOC_RESULT));

  assign wr_ctrl = wr_any & (io_addr == LOC_STATUS);

  assign rd_result = rd_any & (io_addr == LOC_RESULT);

  assign start_ok = wr_start &
                    (st_r.conv_state == CST_IDLE);

  assign conv.start = start_ok;

  assign busy_now = (st_r.conv_state == CST_CONV);

  assign int_edge = ext_int_in & ~st_r.ext_int_prev;

  // status byte assembly
  always_comb begin
    status_byte = ZERO_BYTE;
    status_byte[STAT_BUSY_BIT] = busy_now;
    status_byte[STAT_DIN_HI:STAT_DIN_LO] =
      {digital_input_3, digital_input_2, digital_input_1};
    status_byte[STAT_IRQ_BIT] = st_r.irq_pending;
    status_byte[CHAN_HI:CHAN_LO] = st_r.channel;
  end

  // conversion sequencing
  always_comb begin
    st_nxt         = st_r;
    st_nxt.trigger = 1'b0;
    st_nxt.rvalid  = 1'b0;

    unique case (st_r.conv_state)
      CST_IDLE: begin
        if (start_ok) begin
          st_nxt.conv_state = CST_CONV;
          st_nxt.trigger    = 1'b1;
        end
      end
      CST_CONV: begin
        if (conv.done) begin
          st_nxt.conv_state = CST_HELD;
          st_nxt.result     = adc_sample;
        end
      end
      CST_HELD: begin
        // result read frees the converter
        if (rd_result) begin
          st_nxt.conv_state = CST_IDLE;
        end
      end
    endcase

    if (wr_ctrl) begin
      st_nxt.dout       = io_wdata[CTRL_DOUT_HI:CTRL_DOUT_LO];
      st_nxt.int_enable = io_wdata[CTRL_INTERRUPT_ENABLE_BIT_BIT];
      st_nxt.channel    = io_wdata[CHAN_HI:CHAN_LO];
    end

    // interrupt pin history
    st_nxt.ext_int_prev = ext_int_in;

    st_nxt.irq_pending = (int_edge & st_r.int_enable) |
                         (st_r.irq_pending & ~wr_ctrl);

    for (int i = 0; i < IRQ_LINES; i++) begin
      st_nxt.irq_line[i] = st_nxt.irq_pending &
                           st_nxt.int_enable &
                           (irq_level_sel == 3'(IRQ_LEVEL_LO + 3'(i)));
    end

    // read data, registered one clock after the strobe
    if (rd_any) begin
      st_nxt.rvalid = 1'b1;
      unique case (io_addr)
        LOC_START_ZERO: st_nxt.rdata = ZERO_BYTE;
        LOC_RESULT: st_nxt.rdata = st_r.result;
        LOC_STATUS: st_nxt.rdata = status_byte;
        LOC_STATUS_ALIAS: st_nxt.rdata = status_byte;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r            <= '0;
      st_r.conv_state <= CST_IDLE;
      st_r.result     <= RESULT_RESET;
      st_r.dout       <= DOUT_RESET;
      st_r.channel    <= CHAN_RESET;
      st_r.rdata      <= ZERO_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // conversion timer
  iadc_conv_timer u_timer (
    .clk    (clk),
    .resetn (resetn),
    .conv   (conv.timer)
  );

  // outputs straight from the state register
  assign io_rdata            = st_r.rdata;
  assign io_rvalid           = st_r.rvalid;
  assign conv_trigger        = st_r.trigger;
  assign conv_busy           = st_r.conv_state[1]; // one-hot bit of CST_CONV, no decode
  assign channel_select_bit2 = st_r.channel[2];
  assign channel_select_bit1 = st_r.channel[1];
  assign channel_select_bit0 = st_r.channel[0];
  assign digital_output      = st_r.dout;
  assign irq_line            = st_r.irq_line;

endmodule

// file: tb/iadc_top_sva.sv
/*
  port assertions of the register block.
  assumes one clock and the bus strobes of the host contract.
*/
`timescale 1ns/1ps
module iadc_chk
  import iadc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host bus
  input wire logic io_sel,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [DATA_W-1:0] io_wdata,
  input wire logic [DATA_W-1:0] io_rdata,
  // block outputs and pins
  input wire logic conv_trigger,
  input wire logic conv_busy,
  input wire logic channel_select_bit2,
  input wire logic channel_select_bit1,
  input wire logic channel_select_bit0,
  input wire logic ext_int_in,
  input wire logic [2:0] irq_level_sel,
  input wire logic [IRQ_LINES-1:0] irq_line
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // status read, control write, channel
  wire st_rd = io_sel && io_rd && io_addr[1];
  wire ct_wr = io_sel && io_wr && io_addr == LOC_STATUS;
  wire [2:0] chan = {channel_select_bit2, channel_select_bit1, channel_select_bit0};
  logic [9:0] busy_cnt_r;
  // counts busy cycles of one conversion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) busy_cnt_r <= 10'h000;
    else busy_cnt_r <= conv_busy ? busy_cnt_r + 10'h001 : 10'h000;
  end
  AST_TRIG: assert property ($rose(conv_busy) |-> conv_trigger)
    else $error("busy without trigger");
  AST_LEN: assert property ($fell(conv_busy) |-> busy_cnt_r == 10'(CONV_CYCLES + 1))
    else $error("conversion length wrong");
  AST_ZERO: assert property (io_sel && io_rd && io_addr == LOC_START_ZERO |=> io_rdata == ZERO_BYTE)
    else $error("location 0 not zero");
  AST_BIT7: assert property (st_rd |=> io_rdata[STAT_BUSY_BIT] == $past(conv_busy))
    else $error("busy bit wrong");
  AST_CHAN: assert property (st_rd |=> io_rdata[2:0] == $past(chan))
    else $error("channel bits wrong");
  AST_CTRL: assert property (ct_wr |=> chan == $past(io_wdata[2:0]))
    else $error("channel not loaded");
  AST_ACK: assert property (ct_wr && $stable(ext_int_in) |=> irq_line == '0)
    else $error("irq not acknowledged");
  AST_NOIRQ: assert property (irq_level_sel < IRQ_LEVEL_LO && $stable(irq_level_sel) |=> irq_line == '0)
    else $error("irq on unused level");
endmodule

bind iadc_top iadc_chk chk (.*);

// file: tb/iadc_host.sv
/*
  host processor model: byte reads and writes on the window.
  assumes a read answer one cycle after its strobe.
*/
`timescale 1ns/1ps
module iadc_host
  import iadc_pkg::*;
(
  // clock
  input wire logic clk,
  // bus toward the block
  output logic io_sel,
  output logic [IO_ADDR_W-1:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [DATA_W-1:0] io_wdata,
  // read answer
  input wire logic [DATA_W-1:0] io_rdata,
  input wire logic io_rvalid
);
  // bus idle at time zero
  initial begin
    io_sel = 1'b0;
    io_addr = 2'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(negedge clk);
    io_sel = 1'b1;
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge clk);
    io_sel = 1'b0;
    io_wr = 1'b0;
    io_wdata = ~v; // released data shows no stale value
  endtask
  // read strobe, answer taken with rvalid
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(negedge clk);
    io_sel = 1'b1;
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_sel = 1'b0;
    io_rd = 1'b0;
    v = io_rvalid ? io_rdata : 'x;
  endtask
endmodule

// file: tb/iadc_top_bench.sv
/*
  self-checking bench of the register block driven by the host model.
  assumes the package constants and a 40 MHz clock.
*/
`timescale 1ns/1ps
module iadc_top_bench
  import iadc_pkg::*;
();
  // stimulus and observed signals
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] adc_sample = 8'h00;
  logic digital_input_3 = 1'b0;
  logic digital_input_2 = 1'b0;
  logic digital_input_1 = 1'b0;
  logic ext_int_in = 1'b0;
  logic [2:0] irq_level_sel = 3'h3;
  logic [7:0] d;
  wire io_sel, io_wr, io_rd, io_rvalid, conv_trigger, conv_busy;
  wire channel_select_bit2, channel_select_bit1, channel_select_bit0;
  wire [1:0] io_addr;
  wire [7:0] io_wdata, io_rdata;
  wire [3:0] digital_output;
  wire [5:0] irq_line;
  int n_mismatch = 0;
  int samples_checked = 0;
  localparam logic [7:0] CODES [3] = '{8'h00, 8'h80, 8'hFF};
  // 25 ns clock
  always #12.5 clk = ~clk;
  iadc_top uut (.*);
  iadc_host host (.*);
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask
  // bounded wait for end of conversion
  task automatic wait_done(output int n);
    n = 0;
    while (conv_busy !== 1'b0 && n < 900) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_reset;
    host.rd(LOC_STATUS, d);
    chk(d, 8'h00);
    host.rd(LOC_START_ZERO, d);
    chk(d, ZERO_BYTE);
    chk(digital_output, 4'h0);
  endtask
  task automatic t_conv;
    int n;
    for (int i = 0; i < 3; i++) begin
      adc_sample = CODES[i];
      host.rd(LOC_RESULT, d); // dummy read before start
      host.wr(2'(i % 2), ~CODES[i]);
      chk(conv_busy, 1'b1);
      wait_done(n);
      chk(16'(n), 16'(CONV_CYCLES + 1));
      host.wr(LOC_RESULT, 8'h00);
      chk(conv_busy, 1'b0);
      host.rd(LOC_RESULT, d);
      chk(d, CODES[i]);
    end
  endtask
  task automatic t_ctrl;
    {digital_input_3, digital_input_2, digital_input_1} = 3'h5;
    host.wr(LOC_STATUS, 8'hA5);
    chk(digital_output, 4'hA);
    host.wr(LOC_STATUS_ALIAS, 8'h5A);
    chk(digital_output, 4'hA);
    host.rd(LOC_STATUS, d);
    chk(d, 8'h55);
    host.rd(LOC_STATUS_ALIAS, d);
    chk(d, 8'h55);
  endtask
  task automatic t_irq;
    host.wr(LOC_STATUS, 8'h08);
    ext_int_in = 1'b1;
    repeat (2) @(negedge clk);
    chk(irq_line, 6'h02);
    host.rd(LOC_STATUS, d);
    chk(d, 8'h58);
    host.wr(LOC_STATUS, 8'h08);
    chk(irq_line, 6'h00);
    ext_int_in = 1'b0;
    host.wr(LOC_STATUS, 8'h00);
    ext_int_in = 1'b1;
    repeat (2) @(negedge clk);
    chk(irq_line, 6'h00);
    ext_int_in = 1'b0;
    irq_level_sel = 3'h0;
    host.wr(LOC_STATUS, 8'h08);
    ext_int_in = 1'b1;
    repeat (2) @(negedge clk);
    chk(irq_line, 6'h00);
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog, about two and a half times the expected run
  initial begin
    #150000;
    n_mismatch++;
    tally_and_finish;
  end
  // reset, then the scenarios
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    t_reset;
    t_conv;
    t_ctrl;
    t_irq;
    tally_and_finish;
  end
endmodule
